// file: common/dsd_pkg.sv
// Shared constants and types for the dual UART strap and direction block
package dsd_pkg;

  // Register map, byte addresses, one 32-bit word each
  localparam logic [7:0] REG_TXD   = 8'h00;  // Transmit byte (write)
  localparam logic [7:0] REG_RXD   = 8'h04;  // Receive byte (read, pops)
  localparam logic [7:0] REG_MCR   = 8'h08;  // modem_control_reg
  localparam logic [7:0] REG_ENHANCED_MODE_SELECT_REG  = 8'h0c;  // enhanced_mode_select_reg
  localparam logic [7:0] REG_FEATURE_CONTROL_REG  = 8'h10;  // feature_control_reg
  localparam logic [7:0] REG_STAT  = 8'h14;  // Channel status (read)
  localparam logic [7:0] CH_STRIDE = 8'h20;  // Channel B base
  localparam logic [7:0] REG_GLOB  = 8'h40;  // Strap and host status
  localparam logic [7:0] OFF_MASK  = 8'h1f;  // Offset within channel

  // Field positions
  localparam int MCR_PRE_BIT  = 7;  // Prescale override, 1 = divide by 4
  localparam int MCR_RTS_BIT  = 1;  // Request-to-send, 1 = pin low
  localparam int ENHANCED_MODE_SELECT_REG_INV_BIT = 3;  // Direction polarity invert
  localparam int FEATURE_CONTROL_REG_DIR_BIT = 3;  // Automatic direction enable
  localparam int FEATURE_CONTROL_REG_OS8_BIT = 6;  // 8x sampling when set

  // Timing counts
  localparam logic [1:0] PRE4_LAST  = 2'h3;  // Divide by 4 prescaler wrap
  localparam logic [3:0] OS16_LAST  = 4'hf;  // 16 samples per bit
  localparam logic [3:0] OS8_LAST   = 4'h7;  // 8 samples per bit
  localparam logic [3:0] OS16_HALF  = 4'h7;  // Mid start bit, 16x
  localparam logic [3:0] OS8_HALF   = 4'h3;  // Mid start bit, 8x
  localparam logic [3:0] FRAME_LAST = 4'h9;  // Start, 8 data, stop
  localparam logic [3:0] DATA_LAST  = 4'h8;  // Last data bit index
  localparam int CLK_NS      = 25;
  localparam int RST_MIN_NS  = 40;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  // FIFO geometry
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W      = 6;
  localparam int CNT_W      = 7;
  localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;

  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } dsd_rx_t;

  // Decoded parallel host access
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic rd;
    logic wr;
    logic conflict;
  } dsd_host_t;

endpackage

// file: design/dsd_chan.sv
// One serial channel: 64-byte FIFOs, transmitter and receiver
`timescale 1ns/1ps
module dsd_chan
  import dsd_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             srst,
  // Sample timing
  input  wire logic             tick,
  input  wire logic             os8,
  // Host side
  input  wire logic             tx_push,
  input  wire logic [7:0]       tx_byte,
  input  wire logic             rx_pop,
  output logic      [7:0]       rx_byte,
  output logic      [CNT_W-1:0] tx_level,
  output logic      [CNT_W-1:0] rx_level,
  output logic                  tx_load,
  output logic                  tx_idle,
  // Serial pins
  input  wire logic             rx_in,
  output logic                  tx_out
);

  logic [7:0]       txm [FIFO_DEPTH];  // Transmit FIFO storage
  logic [7:0]       rxm [FIFO_DEPTH];  // Receive FIFO storage
  logic [PTR_W-1:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
  logic [CNT_W-1:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [9:0]       tsh_q, tsh_d;      // Frame being shifted out
  logic [3:0]       tbit_q, tbit_d, ttc_q, ttc_d, rbit_q, rbit_d, rtc_q, rtc_d;
  logic             tact_q, tact_d, tx_q, tx_d;
  logic [7:0]       rsh_q, rsh_d;
  dsd_rx_t          rst_q, rst_d;
  logic             push_ok, rx_wr;
  logic [3:0]       os_last, os_half;

  assign os_last  = os8 ? OS8_LAST : OS16_LAST;
  assign os_half  = os8 ? OS8_HALF : OS16_HALF;
  assign push_ok  = tx_push && (tcnt_q != CNT_FULL);
  assign tx_load  = !tact_q && (tcnt_q != '0) && !srst;
  assign tx_idle  = !tact_q && (tcnt_q == '0);
  assign rx_byte  = rxm[rrp_q];
  assign tx_level = tcnt_q;
  assign rx_level = rcnt_q;
  assign tx_out   = tx_q;

  // Transmit FIFO and shifter next state
  always_comb
  begin
    twp_d  = twp_q + PTR_W'(push_ok);
    trp_d  = trp_q;
    tsh_d  = tsh_q;
    tbit_d = tbit_q;
    ttc_d  = ttc_q;
    tact_d = tact_q;
    if (tx_load)
    begin
      // Frame: stop, data LSB first, start
      tsh_d  = {1'b1, txm[trp_q], 1'b0};
      trp_d  = trp_q + 1'b1;
      tact_d = 1'b1;
      tbit_d = '0;
      ttc_d  = '0;
    end
    else if (tact_q && tick)
    begin
      if (ttc_q == os_last)
      begin
        ttc_d = '0;
        tsh_d = {1'b1, tsh_q[9:1]};
        // Idle only after the whole stop bit
        if (tbit_q == FRAME_LAST)
          tact_d = 1'b0;
        else
          tbit_d = tbit_q + 1'b1;
      end
      else
        ttc_d = ttc_q + 1'b1;
    end
    tcnt_d = tcnt_q + CNT_W'(push_ok) - CNT_W'(tx_load);
    tx_d   = tact_d ? tsh_d[0] : 1'b1;
    if (srst)
    begin
      // Line held high, FIFO emptied
      twp_d  = '0;
      trp_d  = '0;
      tcnt_d = '0;
      tact_d = 1'b0;
      tx_d   = 1'b1;
    end
  end

  // Receiver next state
  always_comb
  begin
    rst_d = rst_q;
    rsh_d = rsh_q;
    rbit_d = rbit_q;
    rtc_d = rtc_q;
    rx_wr = 1'b0;
    case (rst_q)
      RX_IDLE:
      begin
        rtc_d = '0;
        rbit_d = '0;
        if (!rx_in)
          rst_d = RX_START;
      end
      RX_START:
        if (tick)
        begin
          rtc_d = rtc_q + 1'b1;
          if (rtc_q == os_half)
          begin
            // False start if line went back high
            rst_d = rx_in ? RX_IDLE : RX_DATA;
            rtc_d = '0;
          end
        end
      RX_DATA:
        if (tick)
        begin
          rtc_d = rtc_q + 1'b1;
          if (rtc_q == os_last)
          begin
            rtc_d  = '0;
            rsh_d  = {rx_in, rsh_q[7:1]};
            rbit_d = rbit_q + 1'b1;
            if (rbit_q == DATA_LAST - 1'b1)
              rst_d = RX_STOP;
          end
        end
      RX_STOP:
        if (tick)
        begin
          rtc_d = rtc_q + 1'b1;
          if (rtc_q == os_last)
          begin
            rst_d = RX_IDLE;
            rx_wr = rx_in && (rcnt_q != CNT_FULL);
          end
        end
      default:
        rst_d = RX_IDLE;
    endcase
    rwp_d  = rwp_q + PTR_W'(rx_wr);
    rrp_d  = rrp_q + PTR_W'(rx_pop && (rcnt_q != '0));
    rcnt_d = rcnt_q + CNT_W'(rx_wr) - CNT_W'(rx_pop && (rcnt_q != '0));
    if (srst)
    begin
      // Receive input ignored during reset
      rst_d  = RX_IDLE;
      rx_wr  = 1'b0;
      rwp_d  = '0;
      rrp_d  = '0;
      rcnt_d = '0;
    end
  end

  // FIFO storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push_ok && !srst)
      txm[twp_q] <= tx_byte;
    if (rx_wr)
      rxm[rwp_q] <= rsh_q;
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {twp_q, trp_q, rwp_q, rrp_q} <= '0;
      {tcnt_q, rcnt_q} <= '0;
      tsh_q  <= '1;
      {tbit_q, ttc_q, rbit_q, rtc_q} <= '0;
      tact_q <= 1'b0;
      tx_q   <= 1'b1;
      rsh_q  <= '0;
      rst_q  <= RX_IDLE;
    end
    else
    begin
      {twp_q, trp_q, rwp_q, rrp_q} <= {twp_d, trp_d, rwp_d, rrp_d};
      {tcnt_q, rcnt_q} <= {tcnt_d, rcnt_d};
      tsh_q  <= tsh_d;
      {tbit_q, ttc_q, rbit_q, rtc_q} <= {tbit_d, ttc_d, rbit_d, rtc_d};
      tact_q <= tact_d;
      tx_q   <= tx_d;
      rsh_q  <= rsh_d;
      rst_q  <= rst_d;
    end
  end

endmodule

// file: design/dsd_top.sv
// Dual UART straps, host decode, prescaler and RS-485 direction top
`timescale 1ns/1ps

// What this block does
// - Bus style strap high selects strobe host bus
// - Each style decodes its own host pins
// - One host interface, independent channel registers
// - Prescaler strap sampled at reset, high divides 1
// - Modem control bit 7 overrides prescale choice
// - Duplex strap low makes RTS direction outputs
// - Direction low transmitting, polarity bit inverts
// - Feature bit 3 matters only with strap high
// - Receive state only after last stop bit
// - Byte loaded into transmitter restores transmit state
// - Automatic direction off after reset until enabled
// - Reset pin polarity follows bus style strap
// - Reset holds TX high, ignores RX, defaults
// - Each channel has 64-byte transmit/receive FIFOs
// - Receiver samples 16x or 8x per bit
// - Strobe style selects; both only for writes
// - Line style: address bit picks channel
module dsd_top
  import dsd_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Straps and reset pin
  input  wire logic        BUS_STYLE_STRAP,
  input  wire logic        PRESCALER_STRAP,
  input  wire logic        HALF_DUPLEX_STRAP_N,
  input  wire logic        RESET_PIN,
  // Parallel host bus
  input  wire logic        READ_STROBE_N,
  input  wire logic        WRITE_STROBE_N,
  input  wire logic        CHAN_A_SELECT_N,
  input  wire logic        CHAN_B_SELECT_N,
  input  wire logic        READ_NOT_WRITE,
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        CHANNEL_ADDRESS_BIT,
  output logic             HOST_SEL_A,
  output logic             HOST_SEL_B,
  output logic             HOST_RD,
  output logic             HOST_WR,
  // Serial pins
  input  wire logic        RX_A,
  input  wire logic        RX_B,
  output logic             TX_A,
  output logic             TX_B,
  output logic             RTS_N_A,
  output logic             RTS_N_B
);

  // Address match for one channel register
  function automatic logic dsd_hit(logic [7:0] a, logic ch, logic [7:0] off);
    dsd_hit = (a == ((ch ? CH_STRIDE : 8'h00) | off));
  endfunction

  // Host pin decode under either bus style
  function automatic dsd_host_t dsd_host_dec(logic style, logic rd_n, logic wr_n,
                                             logic ca_n, logic cb_n, logic rnw,
                                             logic cs_n, logic a3);
    dsd_host_t h;
    h = '0;
    if (style)
    begin
      h.sel_a = !ca_n;
      h.sel_b = !cb_n;
      h.conflict = !ca_n && !cb_n && !rd_n;
      h.rd = !rd_n && (h.sel_a ^ h.sel_b);
      h.wr = !wr_n && (h.sel_a || h.sel_b);
    end
    else
    begin
      h.sel_a = !cs_n && !a3;
      h.sel_b = !cs_n && a3;
      h.rd = !cs_n && rnw;
      h.wr = !cs_n && !rnw;
    end
    dsd_host_dec = h;
  endfunction

  logic             srst_q, srst_d;         // Pin reset in force
  logic             boot_q;                 // First cycle after async reset seen
  logic             strap_q, strap_d;       // Latched prescaler strap
  logic [1:0]       pre_sel_q, pre_sel_d;   // 1 = divide by 4, per channel
  logic [1:0]       mcr_pre_q, mcr_pre_d;
  logic [1:0]       mcr_rts_q, mcr_rts_d;
  logic [1:0]       enhanced_mode_select_reg_q, enhanced_mode_select_reg_d;         // Direction polarity invert
  logic [1:0]       fdir_q, fdir_d;         // Automatic direction enable
  logic [1:0]       fos8_q, fos8_d;         // 8x sampling
  logic [1:0][1:0]  pre_cnt_q, pre_cnt_d;
  logic [1:0]       xmit_q, xmit_d;         // Direction state, 1 = transmit
  logic [1:0]       rts_q, rts_d;
  logic [1:0]       dir_mode, tick, tx_push, rx_pop, tx_load, tx_idle, tx_w;
  logic [1:0][7:0]  rx_byte;
  logic [1:0][CNT_W-1:0] tx_lvl, rx_lvl;
  logic [31:0]      rdat_d;
  logic             rdy_d, err_d, wr_go, rd_go;
  dsd_host_t        host_q, host_d;
  logic [7:0]       off;

  assign wr_go = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_go = PSEL && PENABLE && PREADY && !PWRITE;
  assign off   = PADDR & OFF_MASK;
  assign TX_A  = tx_w[0];
  assign TX_B  = tx_w[1];
  assign HOST_SEL_A = host_q.sel_a;
  assign HOST_SEL_B = host_q.sel_b;
  assign HOST_RD = host_q.rd;
  assign HOST_WR = host_q.wr;
  assign RTS_N_A = rts_q[0];
  assign RTS_N_B = rts_q[1];

  // Reset pin polarity and host decode follow the bus style strap
  always_comb
  begin
    srst_d = BUS_STYLE_STRAP ? RESET_PIN : !RESET_PIN;
    host_d = dsd_host_dec(BUS_STYLE_STRAP, READ_STROBE_N,
                          WRITE_STROBE_N, CHAN_A_SELECT_N, CHAN_B_SELECT_N,
                          READ_NOT_WRITE, CHIP_SELECT_N, CHANNEL_ADDRESS_BIT);
  end

  // Control registers, prescale latch, per-channel prescaler
  always_comb
  begin
    strap_d   = strap_q;
    pre_sel_d = pre_sel_q;
    mcr_pre_d = mcr_pre_q;
    mcr_rts_d = mcr_rts_q;
    enhanced_mode_select_reg_d    = enhanced_mode_select_reg_q;
    fdir_d    = fdir_q;
    fos8_d    = fos8_q;
    if (!boot_q || srst_q)
    begin
      strap_d   = PRESCALER_STRAP;
      pre_sel_d = {2{!PRESCALER_STRAP}};
    end
    for (int ch = 0; ch < 2; ch++)
    begin
      tx_push[ch] = wr_go && dsd_hit(PADDR, 1'(ch), REG_TXD);
      rx_pop[ch]  = rd_go && dsd_hit(PADDR, 1'(ch), REG_RXD);
      if (wr_go && dsd_hit(PADDR, 1'(ch), REG_MCR))
      begin
        mcr_pre_d[ch] = PWDATA[MCR_PRE_BIT];
        mcr_rts_d[ch] = PWDATA[MCR_RTS_BIT];
        pre_sel_d[ch] = PWDATA[MCR_PRE_BIT];
      end
      if (wr_go && dsd_hit(PADDR, 1'(ch), REG_ENHANCED_MODE_SELECT_REG))
        enhanced_mode_select_reg_d[ch] = PWDATA[ENHANCED_MODE_SELECT_REG_INV_BIT];
      if (wr_go && dsd_hit(PADDR, 1'(ch), REG_FEATURE_CONTROL_REG))
      begin
        fdir_d[ch] = PWDATA[FEATURE_CONTROL_REG_DIR_BIT];
        fos8_d[ch] = PWDATA[FEATURE_CONTROL_REG_OS8_BIT];
      end
      // Divide by 1 ticks every clock, divide by 4 every fourth
      pre_cnt_d[ch] = pre_sel_q[ch] ? pre_cnt_q[ch] + 2'h1 : 2'h0;
      tick[ch] = !pre_sel_q[ch] || (pre_cnt_q[ch] == PRE4_LAST);
      // Strap low forces direction mode; else feature bit decides
      dir_mode[ch] = !HALF_DUPLEX_STRAP_N || fdir_q[ch];
    end
    if (srst_q)
    begin
      // Registers to defaults, prescale comes from strap
      {mcr_pre_d, mcr_rts_d, enhanced_mode_select_reg_d, fdir_d, fos8_d} = '0;
      // A write during reset must not beat the strap reload
      pre_sel_d = {2{!PRESCALER_STRAP}};
      pre_cnt_d = '0;
      tx_push = '0;
      rx_pop = '0;
    end
  end

  // Direction state and request-to-send pins
  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      if (tx_load[ch])
        xmit_d[ch] = 1'b1;
      else if (tx_idle[ch])
        xmit_d[ch] = 1'b0;
      else
        xmit_d[ch] = xmit_q[ch];
      // Low for transmit, high for receive, optionally inverted
      if (dir_mode[ch])
        rts_d[ch] = !xmit_q[ch] ^ enhanced_mode_select_reg_q[ch];
      else
        rts_d[ch] = !mcr_rts_q[ch];
    end
    if (srst_q)
    begin
      xmit_d = '0;
      rts_d  = '1;
    end
  end

  // APB read data and answer, registered during setup
  always_comb
  begin
    rdy_d  = PSEL && !PENABLE;
    err_d  = 1'b0;
    rdat_d = '0;
    if (PADDR == REG_GLOB)
      rdat_d = {27'h0, host_q.conflict, srst_q, HALF_DUPLEX_STRAP_N,
                strap_q, BUS_STYLE_STRAP};
    else if (PADDR < REG_GLOB)
    begin
      case (off)
        REG_TXD:  rdat_d = '0;
        REG_RXD:  rdat_d = {24'h0, rx_byte[PADDR[5]]};
        REG_MCR:  rdat_d = {24'h0, mcr_pre_q[PADDR[5]], 5'h0, mcr_rts_q[PADDR[5]], 1'b0};
        REG_ENHANCED_MODE_SELECT_REG: rdat_d = {28'h0, enhanced_mode_select_reg_q[PADDR[5]], 3'h0};
        REG_FEATURE_CONTROL_REG: rdat_d = {24'h0, 1'b0, fos8_q[PADDR[5]], 2'h0, fdir_q[PADDR[5]], 3'h0};
        REG_STAT: rdat_d = {9'h0, rx_lvl[PADDR[5]], 1'b0, tx_lvl[PADDR[5]],
                            4'h0, pre_sel_q[PADDR[5]], dir_mode[PADDR[5]],
                            tx_idle[PADDR[5]], xmit_q[PADDR[5]]};
        default:  err_d = 1'b1;
      endcase
    end
    else
      err_d = 1'b1;
    if (!rdy_d)
    begin
      err_d  = 1'b0;
      rdat_d = PRDATA;
    end
  end

  // All top-level registers
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      srst_q    <= 1'b0;
      boot_q    <= 1'b0;
      strap_q   <= 1'b0;
      pre_sel_q <= '0;
      {mcr_pre_q, mcr_rts_q, enhanced_mode_select_reg_q, fdir_q, fos8_q} <= '0;
      pre_cnt_q <= '0;
      xmit_q    <= '0;
      rts_q     <= '1;
      host_q    <= '0;
      PRDATA    <= '0;
      PREADY    <= 1'b0;
      PSLVERR   <= 1'b0;
    end
    else
    begin
      srst_q    <= srst_d;
      boot_q    <= 1'b1;
      strap_q   <= strap_d;
      pre_sel_q <= pre_sel_d;
      {mcr_pre_q, mcr_rts_q, enhanced_mode_select_reg_q, fdir_q, fos8_q} <=
        {mcr_pre_d, mcr_rts_d, enhanced_mode_select_reg_d, fdir_d, fos8_d};
      pre_cnt_q <= pre_cnt_d;
      xmit_q    <= xmit_d;
      rts_q     <= rts_d;
      host_q    <= host_d;
      PRDATA    <= rdat_d;
      PREADY    <= rdy_d;
      PSLVERR   <= err_d;
    end
  end

  // Two independent channels with 64-byte FIFOs
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    dsd_chan u_chan (
      .clk      (CLOCK),
      .arst_n   (ARST_N),
      .srst     (srst_q),
      .tick     (tick[ch]),
      .os8      (fos8_q[ch]),
      .tx_push  (tx_push[ch]),
      .tx_byte  (PWDATA[7:0]),
      .rx_pop   (rx_pop[ch]),
      .rx_byte  (rx_byte[ch]),
      .tx_level (tx_lvl[ch]),
      .rx_level (rx_lvl[ch]),
      .tx_load  (tx_load[ch]),
      .tx_idle  (tx_idle[ch]),
      .rx_in    (ch == 0 ? RX_A : RX_B),
      .tx_out   (tx_w[ch])
    );
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  rst_pol_a: assert property ((BUS_STYLE_STRAP ? RESET_PIN : !RESET_PIN) |=> srst_q)
    else $error("reset pin polarity not honoured");
  rst_tx_a: assert property (srst_q |=> TX_A && TX_B && RTS_N_A && RTS_N_B)
    else $error("outputs not at default during reset");
  dir_tx_a: assert property (dir_mode[0] && xmit_q[0] && !enhanced_mode_select_reg_q[0] && !srst_q |=> !RTS_N_A)
    else $error("direction pin not low while transmitting");
  norm_rts_a: assert property (HALF_DUPLEX_STRAP_N && !fdir_q[1] && !srst_q
                               |=> RTS_N_B == !$past(mcr_rts_q[1]))
    else $error("normal request-to-send not followed");
  strap_force_a: assert property (!HALF_DUPLEX_STRAP_N && !xmit_q[0] && !srst_q
                                  |=> RTS_N_A == !$past(enhanced_mode_select_reg_q[0]))
    else $error("strap did not force direction mode");
  dir_hold_a: assert property (xmit_q[0] && !tx_idle[0] && !srst_q |=> xmit_q[0])
    else $error("receive state before stop bit left");
  dir_load_a: assert property (tx_load[1] && !srst_q |=> xmit_q[1])
    else $error("load did not restore transmit state");
  auto_off_a: assert property ($fell(srst_q) |-> fdir_q == 2'b00)
    else $error("automatic direction active after reset");
  pre_latch_a: assert property ($fell(srst_q) |-> pre_sel_q == {2{!$past(PRESCALER_STRAP)}})
    else $error("prescale not sampled from strap");
  pre_over_a: assert property (wr_go && dsd_hit(PADDR, 1'b0, REG_MCR) && !srst_q
                               |=> pre_sel_q[0] == $past(PWDATA[MCR_PRE_BIT]))
    else $error("modem control did not override prescale");
  pre_hold_a: assert property (boot_q && !srst_q && !srst_d && !wr_go |=> $stable(pre_sel_q))
    else $error("prescale changed without reset or override");
  both_rd_a: assert property (BUS_STYLE_STRAP && !CHAN_A_SELECT_N && !CHAN_B_SELECT_N
                              |=> !HOST_RD)
    else $error("read granted with both channels selected");
  line_sel_a: assert property (!BUS_STYLE_STRAP && !CHIP_SELECT_N && CHANNEL_ADDRESS_BIT
                               |=> HOST_SEL_B && !HOST_SEL_A)
    else $error("line style channel decode wrong");

  dir_cycle_c: cover property (tx_load[0] ##[1:1000] !xmit_q[0]);
  apb_err_c: cover property (PREADY && PSLVERR);
  both_wr_c: cover property (HOST_SEL_A && HOST_SEL_B && HOST_WR);

endmodule

// file: tb/dsd_rs485_model.sv
// RS-485 segment shared by the transceivers of both channels
`timescale 1ns/1ps
module dsd_rs485_model
(
  // Channel A line driver
  input  wire logic a_tx,
  input  wire logic a_rts_n,
  // Channel B line driver
  input  wire logic b_tx,
  input  wire logic b_rts_n,
  // Receiver output seen by both channels
  output logic      rx
);
  // A driver is on while its direction pin is low; a released bus rests high on its bias
  assign rx = (a_rts_n ? 1'b1 : a_tx) & (b_rts_n ? 1'b1 : b_tx);
endmodule

// file: tb/dsd_top_bench.sv
// Self-checking bench for the strap, host decode and direction block
`timescale 1ns/1ps
module dsd_top_bench
  import dsd_pkg::*;
;
  // Bench-driven inputs
  logic        CLOCK = 1'b0;
  logic        ARST_N, PSEL, PENABLE, PWRITE;
  logic        PRESCALER_STRAP, HALF_DUPLEX_STRAP_N, RESET_PIN;
  logic [7:0]  PADDR, hp;
  logic [31:0] PWDATA, rdata;
  logic        perr;
  // Design outputs and pin nets
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, HOST_SEL_A, HOST_SEL_B, HOST_RD, HOST_WR;
  wire         TX_A, TX_B, RTS_N_A, RTS_N_B, RX_A, RX_B;
  wire         BUS_STYLE_STRAP, READ_STROBE_N, WRITE_STROBE_N, CHAN_A_SELECT_N;
  wire         CHAN_B_SELECT_N, READ_NOT_WRITE, CHIP_SELECT_N, CHANNEL_ADDRESS_BIT;
  wire  [3:0]  hs = {HOST_SEL_A, HOST_SEL_B, HOST_RD, HOST_WR};
  int          errors = 0, check_count = 0, cyc = 0, n;
  // Rows: style strap, seven host pins, expected {sel_a, sel_b, rd, wr}
  logic [11:0] rows [7] = '{12'haea, 12'hc6d, 12'hd65, 12'h7ca, 12'h795, 12'h7e0,
                            12'ha6c};
  // Bytes channel B should receive, in order
  logic [7:0]  exp_rx [4] = '{8'h11, 8'h21, 8'h22, 8'h5a};

  // Style strap and parallel host pins come from one vector
  assign {BUS_STYLE_STRAP, READ_STROBE_N, WRITE_STROBE_N, CHAN_A_SELECT_N,
          CHAN_B_SELECT_N, READ_NOT_WRITE, CHIP_SELECT_N, CHANNEL_ADDRESS_BIT} = hp;
  assign RX_B = RX_A;

  dsd_top dut_u (.*);
  dsd_rs485_model bus_u (.a_tx(TX_A), .a_rts_n(RTS_N_A), .b_tx(TX_B), .b_rts_n(RTS_N_B),
                         .rx(RX_A));

  // 40 MHz clock
  initial forever #12.5 CLOCK = ~CLOCK;

  // Hang guard
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      finish_test();
    end
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer; read data and error kept in rdata and perr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // Answer taken at the rising edge where PREADY is sampled high
    @(posedge CLOCK);
    while (PREADY !== 1'b1)
      @(posedge CLOCK);
    {rdata, perr} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'b00;
  endtask

  // Wait for a channel's direction pin to reach a level, counting cycles in n
  task automatic wt(input logic ch, input logic v);
    n = 0;
    @(negedge CLOCK);
    while ((ch ? RTS_N_B : RTS_N_A) !== v && n < 1000)
    begin
      @(negedge CLOCK);
      n++;
    end
  endtask

  // Queue k bytes, then time the transmit state against k frames of f cycles
  task automatic xfer(input logic [7:0] a, input int k, input logic [7:0] d, input int f);
    for (int i = 0; i < k; i++)
      apb(1'b1, a, {24'h0, d + 8'(i)});
    wt(a[5], 1'b0);
    wt(a[5], 1'b1);
    chk({31'h0, n > f * k - 12 && n < f * k + 8}, 32'h1);
  endtask

  // Print counts and verdict, then stop
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    {ARST_N, PSEL, PENABLE, PWRITE, RESET_PIN} = 5'h0;
    {PRESCALER_STRAP, HALF_DUPLEX_STRAP_N} = 2'h3;
    {PADDR, PWDATA, hp} = {8'h0, 32'h0, 8'hfe};
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
    chk({27'h0, TX_A, TX_B, RTS_N_A, RTS_N_B, PREADY}, 32'h1e);
    @(posedge CLOCK);
    ARST_N <= 1'b1;
    // Host pin decode in both bus styles
    foreach (rows[i])
    begin
      @(posedge CLOCK);
      hp <= rows[i][11:4];
      RESET_PIN <= ~rows[i][11];
      repeat (2) @(posedge CLOCK);
      @(negedge CLOCK);
      chk({28'h0, hs}, {28'h0, rows[i][3:0]});
    end
    @(posedge CLOCK);
    {hp, RESET_PIN} <= {8'hfe, 1'b0};
    repeat (3) @(posedge CLOCK);
    // Strap prescale, override, unmapped access, channel independence
    apb(1'b0, REG_STAT, 32'h0);
    chk(rdata & 32'hc, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, REG_MCR, 32'h1 << MCR_PRE_BIT);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rdata & 32'h8, 32'h8);
    apb(1'b0, REG_STAT + CH_STRIDE, 32'h0);
    chk(rdata & 32'h8, 32'h0);
    apb(1'b1, REG_MCR, 32'h0);
    // Normal request-to-send on B follows its modem control bit
    apb(1'b1, REG_MCR + CH_STRIDE, 32'h1 << MCR_RTS_BIT);
    repeat (2) @(negedge CLOCK);
    chk({31'h0, RTS_N_B}, 32'h0);
    // Software-enabled direction on A, one then two queued bytes
    apb(1'b1, REG_FEATURE_CONTROL_REG, 32'h1 << FEATURE_CONTROL_REG_DIR_BIT);
    xfer(REG_TXD, 1, 8'h11, 160);
    xfer(REG_TXD, 2, 8'h21, 160);
    // Strap-forced direction on B with its feature bit clear
    @(posedge CLOCK);
    HALF_DUPLEX_STRAP_N <= 1'b0;
    xfer(REG_TXD + CH_STRIDE, 1, 8'h5a, 160);
    foreach (exp_rx[i])
    begin
      apb(1'b0, REG_RXD + CH_STRIDE, 32'h0);
      chk(rdata & 32'hff, {24'h0, exp_rx[i]});
    end
    // 8x sampling on both ends: frames shrink to 80 cycles
    apb(1'b1, REG_FEATURE_CONTROL_REG, (32'h1 << FEATURE_CONTROL_REG_OS8_BIT) | (32'h1 << FEATURE_CONTROL_REG_DIR_BIT));
    apb(1'b1, REG_FEATURE_CONTROL_REG + CH_STRIDE, 32'h1 << FEATURE_CONTROL_REG_OS8_BIT);
    xfer(REG_TXD, 1, 8'h3c, 80);
    apb(1'b0, REG_RXD + CH_STRIDE, 32'h0);
    chk(rdata & 32'hff, 32'h3c);
    // Inverted polarity: receive state drives the pin low
    apb(1'b1, REG_ENHANCED_MODE_SELECT_REG, 32'h1 << ENHANCED_MODE_SELECT_REG_INV_BIT);
    repeat (2) @(negedge CLOCK);
    chk({31'h0, RTS_N_A}, 32'h0);
    // Reset pin, active high in strobe style, held three cycles
    @(posedge CLOCK);
    {PRESCALER_STRAP, HALF_DUPLEX_STRAP_N, RESET_PIN} <= 3'b011;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    chk({30'h0, TX_A, RTS_N_A}, 32'h3);
    @(posedge CLOCK);
    RESET_PIN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    PRESCALER_STRAP <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0);
    chk(rdata & 32'hc, 32'h8);
    finish_test();
  end
endmodule
